/* pkg/fsp_pkg.sv */
package fsp_pkg;

  localparam logic [15:0] NV_ADDR_BLK0 = 16'hFF0D;
  localparam logic [15:0] NV_ADDR_BLK1 = 16'hFF0C;
  localparam logic [7:0] PROT_RESET = 8'hFF;

  localparam int POLARITY_BIT = 7;
  localparam int RNV_BIT = 6;
  localparam int HDIS_BIT = 5;
  localparam int HSIZE_LSB = 3;
  localparam int LDIS_BIT = 2;
  localparam int LSIZE_LSB = 0;

  localparam logic [7:0] REG_PROT = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] OP_PROG = 2'h0;
  localparam logic [1:0] OP_SECT = 2'h1;
  localparam logic [1:0] OP_MASS = 2'h2;

  localparam logic [15:0] HI_BASE [4] = '{16'hF800, 16'hF000, 16'hE000, 16'hC000};
  localparam logic [15:0] HI_TOP = 16'hFFFF;
  localparam logic [15:0] HI_PG_BASE [4] = '{16'hC800, 16'hC000, 16'hB000, 16'h8000};
  localparam logic [15:0] HI_PG_TOP = 16'hCFFF;
  localparam logic [15:0] LO_BASE = 16'h4000;
  localparam logic [15:0] LO_TOP [4] = '{16'h43FF, 16'h47FF, 16'h4FFF, 16'h5FFF};
  localparam logic [15:0] LO_PG_BASE = 16'h8000;
  localparam logic [15:0] LO_PG_TOP [4] = '{16'h83FF, 16'h87FF, 16'h8FFF, 16'h9FFF};

  // Row is the present scenario, bit j set means scenario j may follow.
  localparam logic [7:0] SCEN_ALLOWED [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                              8'h18, 8'h3C, 8'h5A, 8'hFF};

  typedef enum logic [1:0] {
    ST_LD0 = 2'b00,
    ST_LD1 = 2'b01,
    ST_LD2 = 2'b10,
    ST_RUN = 2'b11
  } fsp_state_t;

  function automatic logic [2:0] fsp_scen(input logic [7:0] p);
    return {p[POLARITY_BIT], p[HDIS_BIT], p[LDIS_BIT]};
  endfunction

endpackage

/* rtl/fsp_range_check.sv */
`timescale 1ns/10ps
module fsp_range_check (
  input wire logic [7:0] i_prot,
  input wire logic [15:0] i_addr,
  input wire logic i_paged,
  output logic o_hit,
  output logic o_any
);

  logic [1:0] hsz;
  logic [1:0] lsz;
  logic h_en;
  logic l_en;
  logic in_hi;
  logic in_lo;
  logic in_en;

  always_comb begin
    hsz = i_prot[fsp_pkg::HSIZE_LSB +: 2];
    lsz = i_prot[fsp_pkg::LSIZE_LSB +: 2];
    h_en = !i_prot[fsp_pkg::HDIS_BIT];
    l_en = !i_prot[fsp_pkg::LDIS_BIT];
    if (i_paged) begin
      in_hi = (i_addr >= fsp_pkg::HI_PG_BASE[hsz]) && (i_addr <= fsp_pkg::HI_PG_TOP);
      in_lo = (i_addr >= fsp_pkg::LO_PG_BASE) && (i_addr <= fsp_pkg::LO_PG_TOP[lsz]);
    end else begin
      in_hi = (i_addr >= fsp_pkg::HI_BASE[hsz]) && (i_addr <= fsp_pkg::HI_TOP);
      in_lo = (i_addr >= fsp_pkg::LO_BASE) && (i_addr <= fsp_pkg::LO_TOP[lsz]);
    end
    in_en = (h_en && in_hi) || (l_en && in_lo);
    if (i_prot[fsp_pkg::POLARITY_BIT]) begin
      o_hit = in_en;
      o_any = h_en || l_en;
    end else begin
      // Enabled ranges never span the whole block, so something stays locked.
      o_hit = !in_en;
      o_any = 1'b1;
    end
  end

endmodule

/* rtl/fsp_top.sv */
`timescale 1ns/10ps
module fsp_top #(
  parameter int AW = 8
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [15:0] o_nv_addr,
  output logic o_nv_rd,
  input wire logic [7:0] i_nv_data,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_blk,
  input wire logic [1:0] i_cmd_op,
  input wire logic [15:0] i_cmd_addr,
  input wire logic i_cmd_paged,
  output logic o_cmd_ready,
  output logic o_cmd_launch,
  output logic o_cmd_reject,
  output logic o_irq
);

  typedef struct packed {
    fsp_pkg::fsp_state_t state;
    logic [1:0][7:0] prot;
    logic block_select;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [15:0] nv_addr;
    logic nv_rd;
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic launch;
    logic reject;
    logic cmd_ready;
    logic irq;
  } fsp_regs_t;

  fsp_regs_t st_r;
  fsp_regs_t st_nxt;

  logic [1:0] hit_v;
  logic [1:0] any_v;
  logic [7:0] prot_cur;
  logic [7:0] prot_cand;
  logic prot_wr_ok;
  logic [7:0] wsel;
  logic [7:0] rsel;
  logic cmd_hit;
  logic [2:0] scen_cur;
  logic [2:0] scen_cand;
  logic stat_wr;

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_blk
      fsp_range_check u_rc (
        .i_prot(st_r.prot[b]),
        .i_addr(i_cmd_addr),
        .i_paged(i_cmd_paged),
        .o_hit(hit_v[b]),
        .o_any(any_v[b])
      );
    end
  endgenerate

  assign wsel = {st_r.aw_addr[7:2], 2'b00};
  assign rsel = {i_araddr[7:2], 2'b00};
  assign prot_cur = st_r.prot[st_r.block_select];
  assign stat_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.w_lane0 &&
                   (wsel == fsp_pkg::REG_STAT);

  always_comb begin
    prot_cand = st_r.w_data;
    prot_cand[fsp_pkg::RNV_BIT] = prot_cur[fsp_pkg::RNV_BIT];
    if (!prot_cur[fsp_pkg::HDIS_BIT]) begin
      prot_cand[fsp_pkg::HSIZE_LSB +: 2] = prot_cur[fsp_pkg::HSIZE_LSB +: 2];
    end
    if (!prot_cur[fsp_pkg::LDIS_BIT]) begin
      prot_cand[fsp_pkg::LSIZE_LSB +: 2] = prot_cur[fsp_pkg::LSIZE_LSB +: 2];
    end
  end

  // Scenario table lookup: row is the present scenario.
  assign scen_cur = fsp_pkg::fsp_scen(prot_cur);
  assign scen_cand = fsp_pkg::fsp_scen(prot_cand);
  assign prot_wr_ok = fsp_pkg::SCEN_ALLOWED[scen_cur][scen_cand];

  assign cmd_hit = (i_cmd_op == fsp_pkg::OP_MASS) ? any_v[i_cmd_blk] : hit_v[i_cmd_blk];

  always_comb begin
    logic [1:0] set_v;
    logic [1:0] clr_v;
    set_v = 2'h0;
    clr_v = 2'h0;
    st_nxt = st_r;
    st_nxt.launch = 1'b0;
    st_nxt.reject = 1'b0;

    // The load walk presents each address for one cycle and captures the
    // byte at the end of that same cycle, while the address is still on the pins.
    case (st_r.state)
      fsp_pkg::ST_LD0: begin
        st_nxt.nv_addr = fsp_pkg::NV_ADDR_BLK0;
        st_nxt.nv_rd = 1'b1;
        st_nxt.state = fsp_pkg::ST_LD1;
      end
      fsp_pkg::ST_LD1: begin
        st_nxt.prot[0] = i_nv_data;
        st_nxt.nv_addr = fsp_pkg::NV_ADDR_BLK1;
        st_nxt.state = fsp_pkg::ST_LD2;
      end
      fsp_pkg::ST_LD2: begin
        st_nxt.prot[1] = i_nv_data;
        st_nxt.nv_rd = 1'b0;
        st_nxt.state = fsp_pkg::ST_RUN;
      end
      fsp_pkg::ST_RUN: begin
        st_nxt.state = fsp_pkg::ST_RUN;
      end
      default: begin
        st_nxt.state = fsp_pkg::ST_LD0;
      end
    endcase

    if (i_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = i_awaddr;
    end
    if (i_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = i_wdata[7:0];
      st_nxt.w_lane0 = i_wstrb[0];
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = fsp_pkg::RESP_OKAY;
      case (wsel)
        fsp_pkg::REG_PROT: begin
          if (st_r.w_lane0 && st_r.state == fsp_pkg::ST_RUN && prot_wr_ok) begin
            st_nxt.prot[st_r.block_select] = prot_cand;
          end
        end
        fsp_pkg::REG_CFG: begin
          if (st_r.w_lane0) begin
            st_nxt.block_select = st_r.w_data[0];
          end
        end
        fsp_pkg::REG_STAT: begin
          if (st_r.w_lane0) begin
            clr_v = st_r.w_data[1:0];
          end
        end
        fsp_pkg::REG_MASK: begin
          if (st_r.w_lane0) begin
            st_nxt.mask = st_r.w_data[1:0];
          end
        end
        default: begin
          st_nxt.bresp = fsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

    if (i_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = fsp_pkg::RESP_OKAY;
      case (rsel)
        fsp_pkg::REG_PROT: st_nxt.rdata = prot_cur;
        fsp_pkg::REG_CFG: st_nxt.rdata = {7'h00, st_r.block_select};
        fsp_pkg::REG_STAT: st_nxt.rdata = {6'h00, st_r.stat};
        fsp_pkg::REG_MASK: st_nxt.rdata = {6'h00, st_r.mask};
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.rresp = fsp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // A set flag for the block also holds off every launch there.
    if (i_cmd_valid && st_r.state == fsp_pkg::ST_RUN) begin
      if (cmd_hit) begin
        set_v[i_cmd_blk] = 1'b1;
        st_nxt.reject = 1'b1;
      end else if (st_r.stat[i_cmd_blk]) begin
        st_nxt.reject = 1'b1;
      end else begin
        st_nxt.launch = 1'b1;
      end
    end

    st_nxt.stat = (st_r.stat & ~clr_v) | set_v;
    st_nxt.cmd_ready = (st_nxt.state == fsp_pkg::ST_RUN);
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
      st_r.prot <= {2{fsp_pkg::PROT_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_awready = st_r.awready;
  assign o_wready = st_r.wready;
  assign o_bresp = st_r.bresp;
  assign o_bvalid = st_r.bvalid;
  assign o_arready = st_r.arready;
  assign o_rdata = {24'h000000, st_r.rdata};
  assign o_rresp = st_r.rresp;
  assign o_rvalid = st_r.rvalid;
  assign o_nv_addr = st_r.nv_addr;
  assign o_nv_rd = st_r.nv_rd;
  assign o_cmd_ready = st_r.cmd_ready;
  assign o_cmd_launch = st_r.launch;
  assign o_cmd_reject = st_r.reject;
  assign o_irq = st_r.irq;

  chk_load_seq: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_LD1) |->
      (o_nv_addr == 16'hFF0D) ##1 (o_nv_addr == 16'hFF0C) && (st_r.prot[0] == $past(i_nv_data)))
    else $error("Reset load of block 0 went wrong.");

  chk_rnv_stable: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN) |=>
      $stable(st_r.prot[0][6]) && $stable(st_r.prot[1][6]))
    else $error("Reserved bit changed after load.");

  chk_viol_set: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_cmd_valid && o_cmd_ready && i_cmd_op != fsp_pkg::OP_MASS && hit_v[i_cmd_blk]) |=>
      o_cmd_reject && !o_cmd_launch && st_r.stat[$past(i_cmd_blk)])
    else $error("Protected command was not flagged.");

  chk_mass_refuse: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_cmd_valid && o_cmd_ready && i_cmd_op == fsp_pkg::OP_MASS && any_v[i_cmd_blk]) |=>
      o_cmd_reject && st_r.stat[$past(i_cmd_blk)] && !o_cmd_launch ##1
      (!o_cmd_launch || $past(i_cmd_valid)))
    else $error("Mass erase launched over protected sectors.");

  chk_flag_set_wins: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_cmd_valid && o_cmd_ready && cmd_hit) |=>
      st_r.stat[$past(i_cmd_blk)] && o_cmd_reject)
    else $error("Refused command left its flag clear.");

  chk_stat_sticky: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    !stat_wr |=> (($past(st_r.stat) & ~st_r.stat) == 2'h0))
    else $error("Violation flag dropped without a clear.");

  chk_hsize_lock: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN && !st_r.prot[0][5]) |=> $stable(st_r.prot[0][4:3]))
    else $error("High size changed while high range enabled.");

  chk_lsize_lock: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN && !st_r.prot[1][2]) |=> $stable(st_r.prot[1][1:0]))
    else $error("Low size changed while low range enabled.");

  chk_hsize_lock1: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN && !st_r.prot[1][5]) |=> $stable(st_r.prot[1][4:3]))
    else $error("High size of block 1 changed while enabled.");

  chk_lsize_lock0: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN && !st_r.prot[0][2]) |=> $stable(st_r.prot[0][1:0]))
    else $error("Low size of block 0 changed while enabled.");

  chk_scen_legal: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN && st_nxt.prot[0] != st_r.prot[0]) |->
      fsp_pkg::SCEN_ALLOWED[fsp_pkg::fsp_scen(st_r.prot[0])][fsp_pkg::fsp_scen(st_nxt.prot[0])])
    else $error("Illegal protection scenario transition.");

  chk_scen_legal1: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (st_r.state == fsp_pkg::ST_RUN && st_nxt.prot[1] != st_r.prot[1]) |->
      fsp_pkg::SCEN_ALLOWED[fsp_pkg::fsp_scen(st_r.prot[1])][fsp_pkg::fsp_scen(st_nxt.prot[1])])
    else $error("Illegal scenario transition in block 1.");

  chk_free_launch: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_cmd_valid && o_cmd_ready && !cmd_hit && !st_r.stat[i_cmd_blk]) |=>
      o_cmd_launch && !o_cmd_reject)
    else $error("Unprotected command was not launched.");

  chk_irq_level: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    ##1 (o_irq == |($past(st_nxt.stat) & $past(st_nxt.mask))))
    else $error("Interrupt does not follow status and mask.");

endmodule

/* test/fsp_nv_model.sv */
`timescale 1ns/10ps
// Configuration bytes as the nonvolatile store hands them out during the reset load.
module fsp_nv_model #(
  parameter logic [7:0] BYTE0 = 8'hC3,
  parameter logic [7:0] BYTE1 = 8'hFF
) (
  input wire logic i_mclk,
  input wire logic [15:0] i_nv_addr,
  input wire logic i_nv_rd,
  output logic [7:0] o_nv_data
);
  logic [7:0] last_r = 8'hA5;

  always_ff @(posedge i_mclk) begin
    last_r <= o_nv_data;
  end

  // Outside a read the bus toggles, so a sample one cycle late sees the old byte inverted.
  always_comb begin
    if (i_nv_rd && i_nv_addr == fsp_pkg::NV_ADDR_BLK0) begin
      o_nv_data = BYTE0;
    end else if (i_nv_rd && i_nv_addr == fsp_pkg::NV_ADDR_BLK1) begin
      o_nv_data = BYTE1;
    end else begin
      o_nv_data = ~last_r;
    end
  end
endmodule

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, nv_rd, irq;
  logic cmd_valid, cmd_blk, cmd_paged, cmd_ready, launch, reject;
  logic [7:0] awaddr, araddr, nv_data;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, cmd_op, mask;
  logic [15:0] nv_addr, cmd_addr;
  logic [3:0] wstrb;
  int errors = 0;
  int samples_checked = 0;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  fsp_top #(.AW(8)) i_dut (.i_mclk(mclk), .i_rstn(rstn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_nv_addr(nv_addr), .o_nv_rd(nv_rd), .i_nv_data(nv_data),
    .i_cmd_valid(cmd_valid), .i_cmd_blk(cmd_blk), .i_cmd_op(cmd_op),
    .i_cmd_addr(cmd_addr), .i_cmd_paged(cmd_paged), .o_cmd_ready(cmd_ready),
    .o_cmd_launch(launch), .o_cmd_reject(reject), .o_irq(irq));

  fsp_nv_model i_nv (.i_mclk(mclk), .i_nv_addr(nv_addr), .i_nv_rd(nv_rd),
    .o_nv_data(nv_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, where the registered outputs have settled.
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tk;
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bready & bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) chk(32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tk;
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge mclk);
      ta = arvalid & arready;
      tk = rready & rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tk) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(r, fsp_pkg::RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, {24'h000000, e});
    chk(r, fsp_pkg::RESP_OKAY);
  endtask

  // A refused command must leave its block's flag set; the flag is then cleared.
  task automatic cmd(input logic b, input logic [1:0] op, input logic [15:0] a,
                     input logic pg, input logic ok);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_blk <= b;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_paged <= pg;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(negedge mclk);
    chk({launch, reject}, {ok, !ok});
    if (!ok) begin
      axi_rd(fsp_pkg::REG_STAT, d, r);
      chk(d, b ? 32'h2 : 32'h1);
      chk(irq, mask[b]);
      wr(fsp_pkg::REG_STAT, 8'h03);
      chk(irq, 1'b0);
    end
  endtask

  task automatic t_load;
    rd_chk(fsp_pkg::REG_PROT, 8'hC3);
    wr(fsp_pkg::REG_CFG, 8'h01);
    rd_chk(fsp_pkg::REG_PROT, 8'hFF);
    wr(fsp_pkg::REG_CFG, 8'h00);
    cmd(1'b0, fsp_pkg::OP_PROG, 16'hFF0D, 1'b0, 1'b0);
    cmd(1'b1, fsp_pkg::OP_PROG, 16'hFF0C, 1'b0, 1'b1);
  endtask

  task automatic t_blk0;
    wr(fsp_pkg::REG_MASK, 8'h03);
    mask = 2'h3;
    cmd(1'b0, fsp_pkg::OP_PROG, 16'hF7FF, 1'b0, 1'b1);
    cmd(1'b0, fsp_pkg::OP_PROG, 16'hF800, 1'b0, 1'b0);
    cmd(1'b0, fsp_pkg::OP_SECT, 16'h5FFF, 1'b0, 1'b0);
    cmd(1'b0, fsp_pkg::OP_SECT, 16'h6000, 1'b0, 1'b1);
    cmd(1'b0, 2'h3, 16'h3FFF, 1'b0, 1'b1);
    cmd(1'b0, fsp_pkg::OP_PROG, 16'hC800, 1'b1, 1'b0);
    cmd(1'b0, fsp_pkg::OP_PROG, 16'hC7FF, 1'b1, 1'b1);
    cmd(1'b0, fsp_pkg::OP_PROG, 16'h9FFF, 1'b1, 1'b0);
    cmd(1'b0, fsp_pkg::OP_PROG, 16'hA000, 1'b1, 1'b1);
    cmd(1'b0, fsp_pkg::OP_MASS, 16'h0000, 1'b0, 1'b0);
    cmd(1'b1, fsp_pkg::OP_MASS, 16'h0000, 1'b0, 1'b1);
    wr(fsp_pkg::REG_MASK, 8'h00);
    mask = 2'h0;
    cmd(1'b0, 2'h3, 16'hF800, 1'b0, 1'b0);
  endtask

  task automatic t_blk1;
    logic [31:0] d;
    logic [1:0] r;
    wr(fsp_pkg::REG_CFG, 8'h01);
    wr(fsp_pkg::REG_PROT, 8'h00);
    rd_chk(fsp_pkg::REG_PROT, 8'h40);
    wr(fsp_pkg::REG_PROT, 8'hC0);
    rd_chk(fsp_pkg::REG_PROT, 8'h40);
    wr(fsp_pkg::REG_PROT, 8'h5B);
    rd_chk(fsp_pkg::REG_PROT, 8'h40);
    cmd(1'b1, fsp_pkg::OP_PROG, 16'h4000, 1'b0, 1'b1);
    cmd(1'b1, fsp_pkg::OP_PROG, 16'h4400, 1'b0, 1'b0);
    cmd(1'b1, fsp_pkg::OP_SECT, 16'hF800, 1'b0, 1'b1);
    cmd(1'b1, fsp_pkg::OP_SECT, 16'hF7FF, 1'b0, 1'b0);
    cmd(1'b1, fsp_pkg::OP_MASS, 16'h0000, 1'b0, 1'b0);
    wr(fsp_pkg::REG_PROT, 8'h47);
    rd_chk(fsp_pkg::REG_PROT, 8'h44);
    wr(fsp_pkg::REG_PROT, 8'h47);
    rd_chk(fsp_pkg::REG_PROT, 8'h47);
    cmd(1'b1, fsp_pkg::OP_PROG, 16'h4000, 1'b0, 1'b0);
    cmd(1'b1, fsp_pkg::OP_PROG, 16'hF800, 1'b0, 1'b1);
    wr(fsp_pkg::REG_PROT, 8'h64);
    rd_chk(fsp_pkg::REG_PROT, 8'h64);
    cmd(1'b1, fsp_pkg::OP_PROG, 16'hF800, 1'b0, 1'b0);
    axi_rd(8'h10, d, r);
    chk(d, 32'h0);
    chk(r, fsp_pkg::RESP_SLVERR);
    axi_wr(8'h10, 8'h01, r);
    chk(r, fsp_pkg::RESP_SLVERR);
    wr(fsp_pkg::REG_CFG, 8'h00);
    rd_chk(fsp_pkg::REG_PROT, 8'hC3);
    wstrb <= 4'h0;
    wr(fsp_pkg::REG_CFG, 8'h01);
    wstrb <= 4'hF;
    rd_chk(fsp_pkg::REG_CFG, 8'h00);
    rd_chk(fsp_pkg::REG_PROT, 8'hC3);
  endtask

  initial begin
    int i;
    rstn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {cmd_valid, cmd_blk, cmd_paged} = 3'h0;
    cmd_op = 2'h0;
    cmd_addr = 16'h0000;
    mask = 2'h0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge mclk);
    chk(cmd_ready, 1'b1);
    chk(nv_rd, 1'b0);
    t_load;
    t_blk0;
    t_blk1;
    close_out;
  end

  initial begin
    #1000000;
    errors++;
    close_out;
  end
endmodule
